// [rtl/nand_host_pkg.sv]
package nand_host_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int WE_LOW_NS = 25;
    localparam int WE_HIGH_NS = 25;
    localparam int RE_LOW_NS = 25;
    localparam int BUSY_START_NS = 100;
    localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_HIGH_CYC = (WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RE_LOW_CYC = (RE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_START_CYC = (BUSY_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] CMD_READ_SETUP = 8'h00;
    localparam logic [7:0] CMD_RAND_OUT = 8'h05;
    localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
    localparam logic [7:0] CMD_DUMMY_CONFIRM = 8'h11;
    localparam logic [7:0] CMD_CACHE_WRITE = 8'h15;
    localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
    localparam logic [7:0] CMD_CACHE_READ = 8'h31;
    localparam logic [7:0] CMD_CACHE_READ_END = 8'h3f;
    localparam logic [7:0] CMD_PLANE_READ_SETUP = 8'h60;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_DATA_INPUT = 8'h80;
    localparam logic [7:0] CMD_MP_SETUP = 8'h81;
    localparam logic [7:0] CMD_RAND_IN = 8'h85;
    localparam logic [7:0] CMD_RAND_OUT_CONFIRM = 8'he0;
    localparam logic [7:0] CMD_PLANE_STATUS = 8'hf1;
    localparam logic [7:0] CMD_RESET = 8'hff;
    localparam logic [1:0] KIND_CMD = 2'h0;
    localparam logic [1:0] KIND_ADDR = 2'h1;
    localparam logic [1:0] KIND_WRITE = 2'h2;
    localparam logic [1:0] KIND_READ = 2'h3;
    localparam logic [2:0] ADDR_CYC_FULL = 3'h5;
    localparam logic [2:0] ADDR_CYC_ROW = 3'h3;
    localparam logic [2:0] PLANE_BYTE_FULL = 3'h2;
    localparam logic [2:0] PLANE_BYTE_ROW = 3'h0;
    localparam int PLANE_BIT = 7;
    localparam int STAT_ARRAY_RDY_BIT = 5;
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_CTRL = 4'h8;
    localparam int CMD_KIND_LSB = 8;
    localparam int ST_ENGINE_BIT = 0;
    localparam int ST_REFUSED_BIT = 1;
    localparam int ST_READY_BIT = 2;
    localparam int ST_CACHE_RD_BIT = 3;
    localparam int ST_DUMMY_BIT = 4;
    localparam int ST_PENDING_BIT = 5;
    localparam int ST_BYTE_LSB = 8;
    localparam int CTRL_CE_BIT = 0;
    localparam logic CTRL_CE_RST = 1'b0;

    typedef struct packed {
        logic ceN;
        logic cl;
        logic al;
        logic weN;
        logic reN;
        logic [7:0] ioOut;
        logic ioOe;
    } nandPins_s;

    typedef enum logic [2:0] {ST_IDLE, ST_STROBE, ST_HOLD, ST_WAITWB, ST_READ} st_e;

    typedef struct packed {
        st_e st;
        logic [3:0] cnt;
        nandPins_s pins;
        logic [7:0] rdByte;
        logic [7:0] lastCmd;
        logic [7:0] setupCmd;
        logic [2:0] addrCnt;
        logic plane;
        logic [6:0] page;
        logic [6:0] firstPage;
        logic cacheRd;
        logic dummy;
        logic pending;
        logic refused;
        logic ce;
        logic ack;
        logic [31:0] dat;
    } state_s;
endpackage

// [rtl/nand_host_ctrl.sv]
// Local design decisions: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module nand_host_ctrl (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output nand_host_pkg::nandPins_s pins,
    input wire logic [7:0] ioIn,
    input wire logic readyBusy
);
    nand_host_pkg::state_s q;
    nand_host_pkg::state_s d;
    logic req;
    logic cmdWrite;
    logic [1:0] kind;
    logic [7:0] byteIn;
    logic busy;
    logic allowed;
    logic confirmOk;
    logic refuseSet;
    logic [31:0] rdData;

    assign req = cyc_i && stb_i && !q.ack;
    assign kind = dat_i[nand_host_pkg::CMD_KIND_LSB +: 2];
    assign byteIn = dat_i[7:0];
    assign busy = !readyBusy;
    assign cmdWrite = req && we_i && adr_i == nand_host_pkg::REG_CMD && sel_i[1:0] == 2'b11;

    // Commands the device would ignore are held back here, so software learns early
    always_comb begin
        allowed = 1'b1;
        if (byteIn == nand_host_pkg::CMD_RESET || byteIn == nand_host_pkg::CMD_STATUS) begin
            allowed = 1'b1;
        end else if (q.dummy) begin
            allowed = !busy && byteIn == nand_host_pkg::CMD_MP_SETUP;
        end else if (busy) begin
            allowed = byteIn == nand_host_pkg::CMD_PLANE_STATUS;
        end else if (byteIn == nand_host_pkg::CMD_PLANE_STATUS) begin
            allowed = 1'b1;
        end else if (q.cacheRd) begin
            allowed = byteIn == nand_host_pkg::CMD_CACHE_READ || byteIn == nand_host_pkg::CMD_CACHE_READ_END
                || byteIn == nand_host_pkg::CMD_RAND_OUT || byteIn == nand_host_pkg::CMD_RAND_OUT_CONFIRM;
        end else if (q.pending) begin
            allowed = byteIn == nand_host_pkg::CMD_DATA_INPUT || byteIn == nand_host_pkg::CMD_RAND_IN
                || byteIn == nand_host_pkg::CMD_CACHE_WRITE || byteIn == nand_host_pkg::CMD_PROG_CONFIRM;
        end else begin
            allowed = byteIn != nand_host_pkg::CMD_MP_SETUP;
        end
    end

    always_comb begin
        confirmOk = 1'b1;
        case (byteIn)
            nand_host_pkg::CMD_READ_CONFIRM: begin
                confirmOk = (q.setupCmd == nand_host_pkg::CMD_READ_SETUP && q.addrCnt == nand_host_pkg::ADDR_CYC_FULL)
                    || (q.setupCmd == nand_host_pkg::CMD_PLANE_READ_SETUP
                    && q.addrCnt == nand_host_pkg::ADDR_CYC_ROW);
            end
            nand_host_pkg::CMD_DUMMY_CONFIRM: begin
                confirmOk = q.setupCmd == nand_host_pkg::CMD_DATA_INPUT
                    && q.addrCnt == nand_host_pkg::ADDR_CYC_FULL && !q.plane;
            end
            nand_host_pkg::CMD_CACHE_WRITE: begin
                confirmOk = q.setupCmd == nand_host_pkg::CMD_DATA_INPUT
                    && q.addrCnt == nand_host_pkg::ADDR_CYC_FULL;
            end
            nand_host_pkg::CMD_PROG_CONFIRM: begin
                if (q.setupCmd == nand_host_pkg::CMD_MP_SETUP) begin
                    confirmOk = q.addrCnt == nand_host_pkg::ADDR_CYC_FULL && q.plane
                        && q.page == q.firstPage;
                end else begin
                    confirmOk = q.setupCmd == nand_host_pkg::CMD_DATA_INPUT
                        && q.addrCnt == nand_host_pkg::ADDR_CYC_FULL;
                end
            end
            default: confirmOk = 1'b1;
        endcase
    end

    always_comb begin
        rdData = '0;
        case (adr_i)
            nand_host_pkg::REG_CMD: rdData[7:0] = q.lastCmd;
            nand_host_pkg::REG_STATUS: begin
                rdData[nand_host_pkg::ST_ENGINE_BIT] = q.st != nand_host_pkg::ST_IDLE;
                rdData[nand_host_pkg::ST_REFUSED_BIT] = q.refused;
                rdData[nand_host_pkg::ST_READY_BIT] = readyBusy;
                rdData[nand_host_pkg::ST_CACHE_RD_BIT] = q.cacheRd;
                rdData[nand_host_pkg::ST_DUMMY_BIT] = q.dummy;
                rdData[nand_host_pkg::ST_PENDING_BIT] = q.pending;
                rdData[nand_host_pkg::ST_BYTE_LSB +: 8] = q.rdByte;
            end
            nand_host_pkg::REG_CTRL: rdData[nand_host_pkg::CTRL_CE_BIT] = q.ce;
            default: rdData = '0;
        endcase
    end

    always_comb begin
        d = q;
        refuseSet = 1'b0;
        d.ack = req;
        if (req && !we_i) begin
            d.dat = rdData;
        end
        if (req && we_i && adr_i == nand_host_pkg::REG_CTRL && sel_i[0]) begin
            d.ce = dat_i[nand_host_pkg::CTRL_CE_BIT];
        end
        if (cmdWrite) begin
            if (q.st != nand_host_pkg::ST_IDLE) begin
                refuseSet = 1'b1;
            end else if (kind == nand_host_pkg::KIND_CMD) begin
                if (!allowed || !confirmOk) begin
                    refuseSet = 1'b1;
                end else begin
                    d.lastCmd = byteIn;
                    d.pins.cl = 1'b1;
                    d.pins.ioOut = byteIn;
                    d.pins.ioOe = 1'b1;
                    d.pins.weN = 1'b0;
                    d.cnt = 4'(nand_host_pkg::WE_LOW_CYC - 1);
                    d.st = nand_host_pkg::ST_STROBE;
                    case (byteIn)
                        nand_host_pkg::CMD_READ_SETUP, nand_host_pkg::CMD_PLANE_READ_SETUP,
                        nand_host_pkg::CMD_DATA_INPUT, nand_host_pkg::CMD_MP_SETUP: begin
                            d.setupCmd = byteIn;
                            d.addrCnt = '0;
                        end
                        nand_host_pkg::CMD_CACHE_READ: d.cacheRd = 1'b1;
                        nand_host_pkg::CMD_CACHE_READ_END: d.cacheRd = 1'b0;
                        nand_host_pkg::CMD_DUMMY_CONFIRM: begin
                            d.dummy = 1'b1;
                            d.firstPage = q.page;
                        end
                        nand_host_pkg::CMD_CACHE_WRITE: d.pending = 1'b1;
                        nand_host_pkg::CMD_PROG_CONFIRM: d.pending = 1'b0;
                        nand_host_pkg::CMD_RESET: begin
                            d.cacheRd = 1'b0;
                            d.dummy = 1'b0;
                            d.pending = 1'b0;
                        end
                        default: begin
                        end
                    endcase
                    if (byteIn == nand_host_pkg::CMD_MP_SETUP) begin
                        d.dummy = 1'b0;
                    end
                end
            end else if (kind == nand_host_pkg::KIND_READ) begin
                d.pins.reN = 1'b0;
                d.pins.ioOe = 1'b0;
                d.cnt = 4'(nand_host_pkg::RE_LOW_CYC - 1);
                d.st = nand_host_pkg::ST_READ;
            end else if (busy || q.dummy) begin
                refuseSet = 1'b1;
            end else begin
                d.pins.al = kind == nand_host_pkg::KIND_ADDR;
                d.pins.ioOut = byteIn;
                d.pins.ioOe = 1'b1;
                d.pins.weN = 1'b0;
                d.cnt = 4'(nand_host_pkg::WE_LOW_CYC - 1);
                d.st = nand_host_pkg::ST_STROBE;
                if (kind == nand_host_pkg::KIND_ADDR) begin
                    if ((q.setupCmd == nand_host_pkg::CMD_PLANE_READ_SETUP && q.addrCnt == nand_host_pkg::PLANE_BYTE_ROW)
                        || (q.setupCmd != nand_host_pkg::CMD_PLANE_READ_SETUP
                        && q.addrCnt == nand_host_pkg::PLANE_BYTE_FULL)) begin
                        d.plane = byteIn[nand_host_pkg::PLANE_BIT];
                        d.page = byteIn[6:0];
                    end
                    if (q.addrCnt != 3'h7) begin
                        d.addrCnt = q.addrCnt + 3'h1;
                    end
                end
            end
        end
        case (q.st)
            nand_host_pkg::ST_IDLE: begin
            end
            nand_host_pkg::ST_STROBE: begin
                if (q.cnt == '0) begin
                    d.pins.weN = 1'b1;
                    d.cnt = 4'(nand_host_pkg::WE_HIGH_CYC - 1);
                    d.st = nand_host_pkg::ST_HOLD;
                end else begin
                    d.cnt = q.cnt - 4'h1;
                end
            end
            nand_host_pkg::ST_HOLD: begin
                if (q.cnt == '0) begin
                    d.pins.cl = 1'b0;
                    d.pins.al = 1'b0;
                    d.pins.ioOe = 1'b0;
                    // Ready/busy lags a command; wait so the next order sees it
                    d.cnt = 4'(nand_host_pkg::BUSY_START_CYC - 1);
                    d.st = q.pins.cl ? nand_host_pkg::ST_WAITWB : nand_host_pkg::ST_IDLE;
                end else begin
                    d.cnt = q.cnt - 4'h1;
                end
            end
            nand_host_pkg::ST_WAITWB: begin
                if (q.cnt == '0) begin
                    d.st = nand_host_pkg::ST_IDLE;
                end else begin
                    d.cnt = q.cnt - 4'h1;
                end
            end
            nand_host_pkg::ST_READ: begin
                if (q.cnt == '0) begin
                    d.rdByte = ioIn;
                    d.pins.reN = 1'b1;
                    d.st = nand_host_pkg::ST_IDLE;
                    if (q.lastCmd == nand_host_pkg::CMD_STATUS && ioIn[nand_host_pkg::STAT_ARRAY_RDY_BIT]) begin
                        d.pending = 1'b0;
                    end
                end else begin
                    d.cnt = q.cnt - 4'h1;
                end
            end
            default: d.st = nand_host_pkg::ST_IDLE;
        endcase
        d.pins.ceN = !d.ce;
        // Set beats a same-cycle clear so no refusal is lost
        d.refused = refuseSet || (q.refused && !(req && we_i && adr_i == nand_host_pkg::REG_STATUS && sel_i[0]
            && dat_i[nand_host_pkg::ST_REFUSED_BIT]));
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q <= '0;
            q.st <= nand_host_pkg::ST_IDLE;
            q.pins.ceN <= 1'b1;
            q.pins.weN <= 1'b1;
            q.pins.reN <= 1'b1;
            q.ce <= nand_host_pkg::CTRL_CE_RST;
        end else begin
            q <= d;
        end
    end

    assign dat_o = q.dat;
    assign ack_o = q.ack;
    assign pins = q.pins;

    sequence weLow;
        q.st == nand_host_pkg::ST_STROBE && !q.pins.weN && q.pins.ioOe;
    endsequence
    sequence weRise;
        q.st == nand_host_pkg::ST_HOLD && q.pins.weN && q.pins.ioOe;
    endsequence
    sequence reLow;
        q.st == nand_host_pkg::ST_READ && !q.pins.reN && !q.pins.ioOe;
    endsequence

    AST_WE_PULSE: assert property (@(posedge clk) disable iff (!rstn)
        $fell(q.pins.weN) |-> weLow ##1 weRise) else $error("write strobe malformed");
    AST_DUMMY_GATE: assert property (@(posedge clk) disable iff (!rstn)
        $past(q.dummy) && $fell(q.pins.weN) && q.pins.cl |-> q.pins.ioOut inside {8'h70, 8'hff, 8'h81})
        else $error("forbidden command after dummy confirm");
    AST_CACHE_GATE: assert property (@(posedge clk) disable iff (!rstn)
        $past(q.cacheRd) && $fell(q.pins.weN) && q.pins.cl
        |-> q.pins.ioOut inside {8'h31, 8'h3f, 8'h70, 8'hf1, 8'hff, 8'h05, 8'he0})
        else $error("forbidden command in cache read");
    AST_BUSY_GATE: assert property (@(posedge clk) disable iff (!rstn)
        cmdWrite && kind == nand_host_pkg::KIND_CMD && !readyBusy && q.st == nand_host_pkg::ST_IDLE
        && !(byteIn inside {8'h70, 8'hf1, 8'hff}) |=> q.st == nand_host_pkg::ST_IDLE && q.refused)
        else $error("command sent while busy");
    AST_PLANE_LOW: assert property (@(posedge clk) disable iff (!rstn)
        $rose(q.dummy) |-> !q.plane && q.addrCnt == 3'h5) else $error("dummy confirm with bad address");
    AST_PLANE_HIGH: assert property (@(posedge clk) disable iff (!rstn)
        $fell(q.pins.weN) && q.pins.cl && q.pins.ioOut == 8'h10 && q.setupCmd == 8'h81
        |-> q.plane && q.page == q.firstPage) else $error("second plane address wrong");
    AST_READ_ORDER: assert property (@(posedge clk) disable iff (!rstn)
        $fell(q.pins.weN) && q.pins.cl && q.pins.ioOut == 8'h30 |-> q.addrCnt inside {3'h3, 3'h5})
        else $error("read confirm without address cycles");
    AST_PENDING: assert property (@(posedge clk) disable iff (!rstn)
        q.pending && $fell(q.pins.weN) && q.pins.cl
        |-> q.pins.ioOut inside {8'h80, 8'h85, 8'h15, 8'h10, 8'h70, 8'hf1, 8'hff})
        else $error("operation before array ready seen");
    AST_ACK: assert property (@(posedge clk) disable iff (!rstn)
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o) else $error("bus ack not single cycle");
    // Mode flags must already reflect a command when its strobe goes out
    AST_CACHE_END: assert property (@(posedge clk) disable iff (!rstn)
        $fell(q.pins.weN) && q.pins.cl && q.pins.ioOut == 8'h3f |-> !q.cacheRd)
        else $error("cache read still marked after end command");
    AST_PROG_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
        $fell(q.pins.weN) && q.pins.cl && q.pins.ioOut == 8'h10 |-> !q.pending && !q.dummy)
        else $error("program confirm left a mode flag set");
    AST_PLANE_ROWS: assert property (@(posedge clk) disable iff (!rstn)
        $fell(q.pins.weN) && q.pins.cl && q.pins.ioOut == 8'h30 && q.setupCmd == 8'h60 |-> q.addrCnt == 3'h3)
        else $error("plane read confirm without three address cycles");
    AST_NO_LOAD_AFTER_DUMMY: assert property (@(posedge clk) disable iff (!rstn)
        $fell(q.pins.weN) && !q.pins.cl |-> !q.dummy)
        else $error("address or data sent after dummy confirm");
    AST_REFUSE_QUIET: assert property (@(posedge clk) disable iff (!rstn)
        cmdWrite && kind == nand_host_pkg::KIND_CMD && q.st == nand_host_pkg::ST_IDLE && !(allowed && confirmOk)
        |=> q.st == nand_host_pkg::ST_IDLE && q.refused && q.pins.weN)
        else $error("refused command reached the pins");
    // Plane data comes back one read strobe at a time, bus released
    AST_RE_PULSE: assert property (@(posedge clk) disable iff (!rstn)
        $fell(q.pins.reN) |-> reLow ##1 q.pins.reN)
        else $error("read strobe malformed");
endmodule

// [bench/nand_dev_model.sv]
`timescale 1ns/1ps
module nand_dev_model #(
    parameter int T_XFER = 4,
    parameter int T_ARRAY = 30,
    parameter int T_PROG = 40
) (
    input wire logic clk,
    input wire nand_host_pkg::nandPins_s pins,
    output logic [7:0] ioIn,
    output logic readyBusy
);
    // Array timing shrunk to clock counts; only order matters
    int busyCnt = 0;
    int arrCnt = 0;
    logic [7:0] cmd = 8'h00;
    logic [7:0] col = 8'h00;
    logic [7:0] lastOut = 8'h00;
    logic statMode = 1'b0;
    logic progBusy = 1'b0;
    logic weQ = 1'b1;
    logic reQ = 1'b1;
    logic colSeen = 1'b0;
    logic [7:0] outByte;
    logic [7:0] b;
    logic wr;
    assign readyBusy = (busyCnt == 0);
    assign outByte = statMode ? {1'b0, readyBusy, arrCnt == 0, 5'h00} : col;
    // Released bus shows the inverse, so a stale sample cannot pass
    assign ioIn = (!pins.ceN && !pins.reN) ? outByte : ~lastOut;
    assign b = pins.ioOut;
    assign wr = pins.weN && !weQ && !pins.ceN;
    always @(posedge clk) begin
        weQ <= pins.weN;
        reQ <= pins.reN;
        if (busyCnt > 0) busyCnt <= busyCnt - 1;
        if (arrCnt > 0) arrCnt <= arrCnt - 1;
        if (busyCnt == 1) progBusy <= 1'b0;
        if (pins.reN && !reQ) begin
            lastOut <= outByte;
            col <= col + 8'h01;
        end
        // Only the first column cycle counts; the second holds unused upper bits
        if (wr && pins.al && (cmd == 8'h85 || cmd == 8'h05) && !colSeen) col <= b;
        if (wr && pins.al) colSeen <= 1'b1;
        if (wr && pins.cl && (!progBusy || b == 8'h70 || b == 8'hf1 || b == 8'hff)) begin
            cmd <= b;
            colSeen <= 1'b0;
            statMode <= (b == 8'h70 || b == 8'hf1);
            case (b)
                8'h30: begin
                    busyCnt <= T_ARRAY;
                    arrCnt <= T_ARRAY;
                end
                8'h31: begin
                    busyCnt <= T_XFER + arrCnt;
                    arrCnt <= T_XFER + arrCnt + T_ARRAY;
                    col <= 8'h00;
                end
                8'h3f: begin
                    busyCnt <= T_XFER + arrCnt;
                    arrCnt <= T_XFER + arrCnt;
                    col <= 8'h00;
                end
                8'h15: begin
                    busyCnt <= T_XFER + arrCnt;
                    arrCnt <= T_XFER + arrCnt + T_PROG;
                end
                8'h11: busyCnt <= T_XFER;
                8'h10: begin
                    busyCnt <= arrCnt + T_PROG;
                    arrCnt <= arrCnt + T_PROG;
                    progBusy <= 1'b1;
                end
                8'hff: begin
                    busyCnt <= T_XFER;
                    arrCnt <= 0;
                end
                default: ;
            endcase
        end
    end
endmodule

// [bench/nand_host_ctrl_test.sv]
`timescale 1ns/1ps
`define CHECK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; $display("Error %0t: got %h exp %h", $time, a, b); end end
module nand_host_ctrl_test;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] datW = 32'h0;
    logic [31:0] datR;
    logic [31:0] q;
    logic ack;
    logic [7:0] ioIn;
    logic readyBusy;
    nand_host_pkg::nandPins_s pins;
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;
    nand_host_ctrl dut (.clk(clk), .rstn(rstn), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(datW), .dat_o(datR), .ack_o(ack), .pins(pins), .ioIn(ioIn), .readyBusy(readyBusy));
    nand_dev_model dev (.clk(clk), .pins(pins), .ioIn(ioIn), .readyBusy(readyBusy));
    initial forever #25 clk = ~clk;
    task finish_test;
        $display("Checks %0d, errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Generous ceiling; a hung poll loop ends here
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            finish_test;
        end
    end
    task wbc(input logic w, input logic [3:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datW <= d;
        sel <= 4'hf;
        do @(posedge clk); while (ack !== 1'b1);
        q = datR;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task op(input logic [1:0] k, input logic [7:0] v);
        wbc(1'b1, nand_host_pkg::REG_CMD, {22'h0, k, v});
        do wbc(1'b0, nand_host_pkg::REG_STATUS, 32'h0); while (q[0] !== 1'b0);
    endtask
    task cm(input logic [7:0] v);
        op(nand_host_pkg::KIND_CMD, v);
    endtask
    task ad(input logic [7:0] v);
        op(nand_host_pkg::KIND_ADDR, v);
    endtask
    task rb;
        op(nand_host_pkg::KIND_READ, 8'h00);
    endtask
    task addr5(input logic [7:0] third);
        ad(8'h00);
        ad(8'h00);
        ad(third);
        ad(8'h00);
        ad(8'h00);
    endtask
    task waitRdy;
        do wbc(1'b0, nand_host_pkg::REG_STATUS, 32'h0); while (q[2] !== 1'b1);
    endtask
    task refused(input logic e);
        wbc(1'b0, nand_host_pkg::REG_STATUS, 32'h0);
        `CHECK(q[1], e)
        wbc(1'b1, nand_host_pkg::REG_STATUS, 32'h2);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        `CHECK(pins.ceN, 1'b1)
        wbc(1'b0, nand_host_pkg::REG_CTRL, 32'h0);
        `CHECK(q[0], nand_host_pkg::CTRL_CE_RST)
        wbc(1'b0, 4'hc, 32'h0);
        `CHECK(q, 32'h0)
        wbc(1'b1, nand_host_pkg::REG_CTRL, 32'h1);
        `CHECK(pins.ceN, 1'b0)
        cm(8'h00);
        addr5(8'h00);
        cm(8'h30);
        refused(1'b0);
        cm(8'h80);
        refused(1'b1);
        waitRdy;
        cm(8'h31);
        waitRdy;
        `CHECK(q[3], 1'b1)
        rb;
        `CHECK(q[15:8], 8'h00)
        rb;
        `CHECK(q[15:8], 8'h01)
        cm(8'h80);
        refused(1'b1);
        cm(8'h3f);
        waitRdy;
        `CHECK(q[3], 1'b0)
        rb;
        `CHECK(q[15:8], 8'h00)
        wbc(1'b0, nand_host_pkg::REG_CMD, 32'h0);
        `CHECK(q[7:0], 8'h3f)
        cm(8'h80);
        addr5(8'h03);
        op(nand_host_pkg::KIND_WRITE, 8'ha5);
        cm(8'h15);
        refused(1'b0);
        waitRdy;
        `CHECK(q[5], 1'b1)
        cm(8'h00);
        refused(1'b1);
        cm(8'h70);
        do rb; while (q[13] !== 1'b1);
        wbc(1'b0, nand_host_pkg::REG_STATUS, 32'h0);
        `CHECK(q[5], 1'b0)
        cm(8'h80);
        addr5(8'h05);
        op(nand_host_pkg::KIND_WRITE, 8'h11);
        cm(8'h11);
        wbc(1'b0, nand_host_pkg::REG_STATUS, 32'h0);
        `CHECK(q[4], 1'b1)
        cm(8'h00);
        refused(1'b1);
        cm(8'h70);
        refused(1'b0);
        waitRdy;
        cm(8'h81);
        addr5(8'h85);
        op(nand_host_pkg::KIND_WRITE, 8'h22);
        cm(8'h10);
        refused(1'b0);
        `CHECK(q[4], 1'b0)
        waitRdy;
        cm(8'h80);
        addr5(8'h85);
        cm(8'h11);
        refused(1'b1);
        cm(8'h60);
        ad(8'h05);
        ad(8'h00);
        ad(8'h00);
        cm(8'h60);
        ad(8'h85);
        ad(8'h00);
        ad(8'h00);
        cm(8'h30);
        refused(1'b0);
        waitRdy;
        cm(8'hf1);
        rb;
        `CHECK(q[15:8], 8'h60)
        cm(8'h00);
        addr5(8'h80);
        cm(8'h05);
        ad(8'h07);
        ad(8'h00);
        cm(8'he0);
        rb;
        `CHECK(q[15:8], 8'h07)
        cm(8'h60);
        ad(8'h05);
        ad(8'h00);
        cm(8'h30);
        refused(1'b1);
        finish_test;
    end
endmodule
